// File: design/xcsd_params.svh
/*
  Constants for the X-Bus chip-select decoder: the fixed port addresses,
  the address pattern of an I/O cycle, reset levels of the selects and
  the default count of programmable selects.
  Assumes it is included by bare name wherever the decoder needs it.
*/
`ifndef XCSD_PARAMS_SVH
`define XCSD_PARAMS_SVH

// fixed keyboard-controller ports, full 20-bit system address
`define XCSD_KBD_DATA_PORT 20'h00060
`define XCSD_KBD_CMD_PORT 20'h00064

// fixed microcontroller ports, full 20-bit system address
`define XCSD_MICRO_DATA_PORT 20'h00062
`define XCSD_MICRO_CMD_PORT 20'h00066

// latched address bits 23..17 must be zero for an I/O port hit
`define XCSD_LA_IO_PATTERN 7'h00

// system address bits above the 16-bit I/O space must be zero
`define XCSD_SA_IO_UPPER 4'h0

// inactive level of every select and buffer control
`define XCSD_SELECT_IDLE 1'h1

// idle level of the ISA command strobes, active low
`define XCSD_STROBE_IDLE 1'h1

// idle level of the DMA acknowledge summary, active low
`define XCSD_DMA_IDLE 1'h1

// default number of programmable chip selects
`define XCSD_PROG_CS_COUNT 2

// largest number of programmable chip selects the logic serves
`define XCSD_PROG_CS_MAX 8

`endif

// File: design/xcsd_pkg.sv
/*
  Types shared by the X-Bus chip-select decoder and its range comparator.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package xcsd_pkg;

  // ISA system address, bits 19..0
  typedef logic [19:0] xcsd_sa_type;

  // ISA latched address, bits 23..17
  typedef logic [6:0] xcsd_la_type;

  // 16-bit I/O port address used by the programmable ranges
  typedef logic [15:0] xcsd_io_addr_type;

endpackage : xcsd_pkg

// File: design/xcsd_range_match.sv
/*
  One programmable I/O range comparator: a hit when the port address
  agrees with the base in every bit that the mask leaves clear.
  Assumes base and mask are steady configuration from the same clock.
*/
module xcsd_range_match (
  input wire logic enable_i,
  input wire xcsd_pkg::xcsd_io_addr_type port_addr_i,
  input wire xcsd_pkg::xcsd_io_addr_type base_i,
  input wire xcsd_pkg::xcsd_io_addr_type mask_i,
  output logic hit_o
);
  import xcsd_pkg::*;

  // masked compare, set mask bits are do-not-care
  always_comb begin
    hit_o = enable_i && (((port_addr_i ^ base_i) & ~mask_i) == '0);
  end

endmodule : xcsd_range_match

// File: design/xcsd_decoder.sv
/*
  X-Bus chip-select decoder: keyboard-controller select, microcontroller
  select and a set of programmable range selects, plus the X-Bus data
  buffer output enable and direction.
  Assumes the ISA address and command pins are asynchronous to clk_sys_i
  and are held steady for several clocks during a command; range,
  master and configuration inputs come from logic on clk_sys_i.
*/
`include "xcsd_params.svh"

// Notes on behaviour
// - keyboard select low on I/O read or write to port 60h or 64h
// - microcontroller select low on I/O read or write to port 62h or 66h
// - fixed selects compare full SA[19:0] and LA[23:17], exact match only
// - option turns the keyboard select pin into a general purpose output
// - all selects high in reset and after reset; in power-on suspend all but a reassigned keyboard pin
// - programmable selects low only for PCI-master I/O cycles inside their range
// - buffer enable active while a programmable select is active, buffer direction only for reads
// - buffer direction low for every non-DMA I/O read cycle outside reset and power-on suspend
module xcsd_decoder #(
  parameter int PROG_CS_COUNT = `XCSD_PROG_CS_COUNT
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire xcsd_pkg::xcsd_sa_type sa_i,
  input wire xcsd_pkg::xcsd_la_type la_i,
  input wire logic io_read_n_i,
  input wire logic io_write_n_i,
  input wire logic dma_ack_n_i,
  input wire logic pci_master_cycle_i,
  input wire logic power_on_suspend_i,
  input wire logic kbd_general_purpose_out_en_i,
  input wire logic general_purpose_out_level_i,
  input wire logic [PROG_CS_COUNT-1:0] prog_enable_i,
  input wire logic [PROG_CS_COUNT-1:0][15:0] prog_base_i,
  input wire logic [PROG_CS_COUNT-1:0][15:0] prog_mask_i,
  output logic kbd_ctrl_select_n_o,
  output logic micro_ctrl_select_n_o,
  output logic [PROG_CS_COUNT-1:0] prog_select_n_o,
  output logic xbus_buf_output_en_n_o,
  output logic xbus_buf_direction_n_o
);
  import xcsd_pkg::*;

  // width of the bundle of pins that pass the synchroniser
  localparam int PIN_WIDTH = 20 + 7 + 3;

  // refuse counts the select logic is not built for
  if (PROG_CS_COUNT < 1 || PROG_CS_COUNT > `XCSD_PROG_CS_MAX) begin : g_bad_count
    $error("xcsd_decoder: PROG_CS_COUNT out of range");
  end

  // synchroniser state, first and second stage
  logic [PIN_WIDTH-1:0] pin_meta_reg;
  logic [PIN_WIDTH-1:0] pin_meta_next;
  logic [PIN_WIDTH-1:0] pin_sync_reg;
  logic [PIN_WIDTH-1:0] pin_sync_next;

  // output state
  logic kbd_sel_n_reg;
  logic kbd_sel_n_next;
  logic micro_sel_n_reg;
  logic micro_sel_n_next;
  logic [PROG_CS_COUNT-1:0] prog_sel_n_reg;
  logic [PROG_CS_COUNT-1:0] prog_sel_n_next;
  logic buf_oe_n_reg;
  logic buf_oe_n_next;
  logic buf_dir_n_reg;
  logic buf_dir_n_next;

  // reset tail, stands for the first cycle after release
  logic rst_tail_reg;
  logic rst_tail_next;

  // synchronised copies of the pins
  xcsd_sa_type sa_sync;
  xcsd_la_type la_sync;
  logic io_read_sync;
  logic io_write_sync;
  logic dma_sync;

  // decode terms
  logic io_cycle;
  logic full_io_space;
  logic kbd_hit;
  logic micro_hit;
  logic [PROG_CS_COUNT-1:0] range_hit;
  logic [PROG_CS_COUNT-1:0] prog_hit;
  logic any_prog_hit;

  // synchroniser next values, idle levels under reset
  // address bundle safe only while the command holds it steady;
  // a moving address could show a mixed word for one cycle
  // flushing both stages keeps a stale strobe from decoding
  // in the first cycles after release
  always_comb begin
    pin_meta_next = {sa_i, la_i, io_read_n_i, io_write_n_i, dma_ack_n_i};
    pin_sync_next = pin_meta_reg;
    if (srst_i) begin
      pin_meta_next = {20'h00000, `XCSD_LA_IO_PATTERN, `XCSD_STROBE_IDLE,
                       `XCSD_STROBE_IDLE, `XCSD_DMA_IDLE};
      pin_sync_next = {20'h00000, `XCSD_LA_IO_PATTERN, `XCSD_STROBE_IDLE,
                       `XCSD_STROBE_IDLE, `XCSD_DMA_IDLE};
    end
  end

  // synchroniser registers, two stages for every pin
  always_ff @(posedge clk_sys_i) begin
    pin_meta_reg <= pin_meta_next;
    pin_sync_reg <= pin_sync_next;
  end

  // reset tail: one cycle of hold past release, so the general
  // purpose pin stays high while the synchronisers refill
  always_comb begin
    rst_tail_next = srst_i;
  end

  // reset tail register
  always_ff @(posedge clk_sys_i) begin
    rst_tail_reg <= rst_tail_next;
  end

  // unpack the second stage only
  always_comb begin
    sa_sync = pin_sync_reg[29:10];
    la_sync = pin_sync_reg[9:3];
    io_read_sync = ~pin_sync_reg[2];
    io_write_sync = ~pin_sync_reg[1];
    dma_sync = ~pin_sync_reg[0];
  end

  // qualify an I/O command that is not a DMA transfer
  always_comb begin
    io_cycle = (io_read_sync || io_write_sync) && !dma_sync;
  end

  // fixed port decode against the full address
  // a select opens three edges after the command is seen and closes
  // three edges after it ends; aliases above 16 bits never hit
  always_comb begin
    full_io_space = (la_sync == `XCSD_LA_IO_PATTERN);
    kbd_hit = io_cycle && full_io_space &&
              (sa_sync == `XCSD_KBD_DATA_PORT || sa_sync == `XCSD_KBD_CMD_PORT);
    micro_hit = io_cycle && full_io_space &&
                (sa_sync == `XCSD_MICRO_DATA_PORT ||
                 sa_sync == `XCSD_MICRO_CMD_PORT);
  end

  // one range comparator per programmable select
  // ranges overlapping a fixed port select both chips: software's care
  for (genvar i = 0; i < PROG_CS_COUNT; i++) begin : g_range
    xcsd_range_match u_match (
      .enable_i(prog_enable_i[i]),
      .port_addr_i(sa_sync[15:0]),
      .base_i(prog_base_i[i]),
      .mask_i(prog_mask_i[i]),
      .hit_o(range_hit[i])
    );
  end

  // programmable hits need a PCI-master I/O cycle in 16-bit space
  // master flag is same-clock, so it leads the pins by two edges
  always_comb begin
    prog_hit = '0;
    if (io_cycle && pci_master_cycle_i && full_io_space &&
        sa_sync[19:16] == `XCSD_SA_IO_UPPER) begin
      prog_hit = range_hit;
    end
    any_prog_hit = |prog_hit;
  end

  // next values of the selects and buffer controls
  // reset and its tail win over everything, suspend over decode
  // a reassigned keyboard pin carries its level outside reset only
  always_comb begin
    kbd_sel_n_next = `XCSD_SELECT_IDLE;
    micro_sel_n_next = `XCSD_SELECT_IDLE;
    prog_sel_n_next = '1;
    buf_oe_n_next = `XCSD_SELECT_IDLE;
    buf_dir_n_next = `XCSD_SELECT_IDLE;
    if (srst_i || rst_tail_reg) begin
      // everything parked high in reset, option or not
      kbd_sel_n_next = `XCSD_SELECT_IDLE;
    end else if (power_on_suspend_i) begin
      // suspend keeps selects high, a reassigned pin keeps its level
      if (kbd_general_purpose_out_en_i) begin
        kbd_sel_n_next = general_purpose_out_level_i;
      end
    end else begin
      if (kbd_general_purpose_out_en_i) begin
        kbd_sel_n_next = general_purpose_out_level_i;
      end else begin
        kbd_sel_n_next = ~kbd_hit;
      end
      micro_sel_n_next = ~micro_hit;
      prog_sel_n_next = ~prog_hit;
      // buffer opened for every X-Bus peripheral selected
      buf_oe_n_next = ~(any_prog_hit || micro_hit ||
                        (kbd_hit && !kbd_general_purpose_out_en_i));
      // direction toward the host on every I/O read that is not a DMA transfer
      buf_dir_n_next = ~(io_cycle && io_read_sync);
    end
  end

  // output registers
  // registered so the selects never glitch on a decode race
  always_ff @(posedge clk_sys_i) begin
    kbd_sel_n_reg <= kbd_sel_n_next;
    micro_sel_n_reg <= micro_sel_n_next;
    prog_sel_n_reg <= prog_sel_n_next;
    buf_oe_n_reg <= buf_oe_n_next;
    buf_dir_n_reg <= buf_dir_n_next;
  end

  // outputs straight from the registers
  assign kbd_ctrl_select_n_o = kbd_sel_n_reg;
  assign micro_ctrl_select_n_o = micro_sel_n_reg;
  assign prog_select_n_o = prog_sel_n_reg;
  assign xbus_buf_output_en_n_o = buf_oe_n_reg;
  assign xbus_buf_direction_n_o = buf_dir_n_reg;

endmodule : xcsd_decoder

// File: test/xcsd_periph_model.sv
/* keyboard controller chip stand-in: counts each select it sees.
   assumes an active-low select sampled on clk_sys_i. */
module xcsd_periph_model (
  input wire logic clk_sys_i,
  input wire logic select_n_i,
  output int hits_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_reg = 1'h1;
  int count_reg = 0;
  // one count per select that opens
  always @(posedge clk_sys_i) begin
    if (last_reg === 1'h1 && select_n_i === 1'h0) count_reg <= count_reg + 1;
    last_reg <= select_n_i;
  end
  assign hits_o = count_reg;
endmodule : xcsd_periph_model

// File: test/xcsd_decoder_checker.sv
/* output relations of the chip-select decoder.
   assumes a bind to xcsd_decoder; pins held 5 edges give a settled decode. */
module xcsd_decoder_checker #(parameter int PROG_CS_COUNT = 2) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire xcsd_pkg::xcsd_sa_type sa_i,
  input wire xcsd_pkg::xcsd_la_type la_i,
  input wire logic io_read_n_i,
  input wire logic io_write_n_i,
  input wire logic dma_ack_n_i,
  input wire logic pci_master_cycle_i,
  input wire logic power_on_suspend_i,
  input wire logic kbd_general_purpose_out_en_i,
  input wire logic general_purpose_out_level_i,
  input wire logic kbd_ctrl_select_n_o,
  input wire logic micro_ctrl_select_n_o,
  input wire logic [PROG_CS_COUNT-1:0] prog_select_n_o,
  input wire logic xbus_buf_output_en_n_o,
  input wire logic xbus_buf_direction_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import xcsd_pkg::*;
  // pin snapshot, qualified i/o cycle, idle summary of all outputs but the keyboard select
  wire [33:0] pins = {sa_i, la_i, io_read_n_i, io_write_n_i, dma_ack_n_i, pci_master_cycle_i,
    power_on_suspend_i, kbd_general_purpose_out_en_i, general_purpose_out_level_i};
  wire g = kbd_general_purpose_out_en_i;
  wire io = (!io_read_n_i || !io_write_n_i) && dma_ack_n_i && la_i == 7'h00 && !power_on_suspend_i;
  wire hi = micro_ctrl_select_n_o && &prog_select_n_o && xbus_buf_output_en_n_o
    && xbus_buf_direction_n_o;
  default clocking @(posedge clk_sys_i);
  endclocking
  default disable iff (srst_i);
  sequence s_st;
    $stable(pins) [*5];
  endsequence
  // address bit 2 free: 60h/64h and 62h/66h
  property p_kbd; s_st ##0 io && !g && {sa_i[19:3], sa_i[1:0]} == 19'h00030
    |-> !kbd_ctrl_select_n_o; endproperty
  a_kbd: assert property (p_kbd) else $error("kbd select idle");
  property p_mc; s_st ##0 io && {sa_i[19:3], sa_i[1:0]} == 19'h00032
    |-> !micro_ctrl_select_n_o; endproperty
  a_mc: assert property (p_mc) else $error("micro select idle");
  property p_la; s_st ##0 la_i != 7'h00
    |-> micro_ctrl_select_n_o && (g || kbd_ctrl_select_n_o); endproperty
  a_la: assert property (p_la) else $error("select on upper address");
  property p_gpo; s_st ##0 g |-> kbd_ctrl_select_n_o == general_purpose_out_level_i; endproperty
  a_gpo: assert property (p_gpo) else $error("gpo level wrong");
  property p_rst; disable iff (1'b0) srst_i |=> (kbd_ctrl_select_n_o && hi) [*2]; endproperty
  a_rst: assert property (p_rst) else $error("output low in reset");
  property p_pci; s_st ##0 !pci_master_cycle_i |-> &prog_select_n_o; endproperty
  a_pci: assert property (p_pci) else $error("range select without pci");
  property p_oe; !(&prog_select_n_o) |-> !xbus_buf_output_en_n_o; endproperty
  a_oe: assert property (p_oe) else $error("buffer off with range select");
  property p_dir; s_st ##0 !io_read_n_i && dma_ack_n_i && !power_on_suspend_i
    |-> !xbus_buf_direction_n_o; endproperty
  a_dir: assert property (p_dir) else $error("direction high on read");
  property p_idle; s_st ##0 (!dma_ack_n_i || io_read_n_i && io_write_n_i) |-> hi; endproperty
  a_idle: assert property (p_idle) else $error("select without cycle");
endmodule : xcsd_decoder_checker
bind xcsd_decoder xcsd_decoder_checker #(.PROG_CS_COUNT(PROG_CS_COUNT)) chk_u (.*);

// File: test/test_xbus_chip_select_decoder.sv
/* random i/o cycle bench for xcsd_decoder against a reference decode.
   assumes the decoder, its checker and the peripheral model. */
module test_xbus_chip_select_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import xcsd_pkg::*;
  logic clk_sys_i = 1'h0, srst_i = 1'h1, io_read_n_i, io_write_n_i, dma_ack_n_i;
  logic pci_master_cycle_i, power_on_suspend_i, kbd_general_purpose_out_en_i;
  logic general_purpose_out_level_i, kbd_ctrl_select_n_o, micro_ctrl_select_n_o;
  logic xbus_buf_output_en_n_o, xbus_buf_direction_n_o, io, kh, mh;
  logic [1:0] prog_enable_i, prog_select_n_o, ph;
  logic [1:0][15:0] prog_base_i, prog_mask_i;
  logic [5:0] want;
  xcsd_sa_type sa_i;
  xcsd_la_type la_i;
  int err_total = 0, n_tests = 0, hits, k;
  wire [5:0] outs = {kbd_ctrl_select_n_o, micro_ctrl_select_n_o, prog_select_n_o,
    xbus_buf_output_en_n_o, xbus_buf_direction_n_o};
  xcsd_decoder dut_u (.*);
  xcsd_periph_model kbc_u (.clk_sys_i(clk_sys_i), .select_n_i(kbd_ctrl_select_n_o), .hits_o(hits));
  // 250 MHz system clock
  initial forever #2 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t: got %b want %b", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  // one random cycle on the pins, ranges near the address
  task automatic drive;
    k = $urandom % 3;
    {io_read_n_i, io_write_n_i} = {k != 0, k != 1};
    sa_i = {4'($urandom % 5 == 0), 8'h00, 8'h60 + 8'($urandom % 8)};
    la_i = 7'($urandom % 8 == 0);
    dma_ack_n_i = $urandom % 6 != 0;
    power_on_suspend_i = $urandom % 9 == 0;
    kbd_general_purpose_out_en_i = $urandom % 7 == 0;
    {prog_enable_i, general_purpose_out_level_i, pci_master_cycle_i} = 4'($urandom);
    prog_base_i = {sa_i[15:0] ^ 16'($urandom % 32), sa_i[15:0]};
    prog_mask_i = {16'h000f, 16'h0000};
  endtask : drive
  // reference decode of the held pins
  task automatic model;
    io = (!io_read_n_i || !io_write_n_i) && dma_ack_n_i && !power_on_suspend_i && la_i == 7'h00;
    kh = io && !kbd_general_purpose_out_en_i && (sa_i == 20'h00060 || sa_i == 20'h00064);
    mh = io && (sa_i == 20'h00062 || sa_i == 20'h00066);
    for (k = 0; k < 2; k++) begin
      ph[k] = prog_enable_i[k] && pci_master_cycle_i && io && sa_i[19:16] == 4'h0
        && ((sa_i[15:0] ^ prog_base_i[k]) & ~prog_mask_i[k]) == 16'h0;
    end
    want = {kbd_general_purpose_out_en_i ? general_purpose_out_level_i : !kh, !mh, ~ph,
      !(kh || mh || |ph), io_read_n_i || !dma_ack_n_i || power_on_suspend_i};
  endtask : model
  // main sequence, a reset in mid-run
  initial begin
    void'($urandom(32'h1986));
    drive;
    repeat (10) @(negedge clk_sys_i);
    chk(outs, 6'h3f);
    for (int n = 0; n < 400; n++) begin
      drive;
      srst_i = n == 200;
      model;
      if (srst_i) want = 6'h3f;
      repeat (6) @(negedge clk_sys_i);
      chk(outs, want);
    end
    chk({5'h00, hits > 0}, 6'h01);
    finish_test;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    finish_test;
  end
endmodule : test_xbus_chip_select_decoder
